// [include/fan_post_pkg.sv]
/*
  Constants and types for the fan duty post-processing block: register
  offsets, field positions, reset values and ramp timing.
  Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package fan_post_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [7:0] OFF_RAMP_SLOWDOWN   = 8'h10;
  localparam logic [7:0] OFF_ACOUSTICS_ONE   = 8'h62;
  localparam logic [7:0] OFF_ACOUSTICS_TWO   = 8'h63;
  localparam logic [7:0] OFF_R1_CRIT_LIMIT   = 8'h6A;
  localparam logic [7:0] OFF_LOCAL_CRIT_LIMIT = 8'h6B;
  localparam logic [7:0] OFF_R2_CRIT_LIMIT   = 8'h6C;
  localparam logic [7:0] OFF_R1_LOCAL_HYST   = 8'h6D;
  localparam logic [7:0] OFF_R2_HYST         = 8'h6E;
  localparam logic [7:0] OFF_STATUS          = 8'h70;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] RST_RAMP_SLOWDOWN = 8'h00;
  localparam logic [7:0] RST_ACOUSTICS     = 8'h00;
  localparam logic [7:0] RST_CRIT_LIMIT    = 8'h64;
  localparam logic [7:0] RST_HYST_PAIR     = 8'h44;
  localparam logic [7:0] RST_HYST_R2       = 8'h40;

  // ==========================================================================
  // Field positions.
  localparam int SLOW_R1_BIT     = 0;
  localparam int SLOW_LOCAL_BIT  = 1;
  localparam int SLOW_R2_BIT     = 2;
  localparam int STRETCH_BIT     = 7;
  localparam int KEEP_ONE_BIT    = 5;
  localparam int HYST_HI_LSB     = 4;
  localparam int HYST_LO_LSB     = 0;
  localparam int RAMP_HI_LSB     = 4;
  localparam int RAMP_LO_LSB     = 0;

  // ==========================================================================
  // Ramp timing: full-scale ramp time per code in tenths of a second.
  localparam int CLK_HZ       = 20_000_000;
  localparam int DUTY_STEPS   = 255;
  localparam int SLOW_FACTOR  = 4;
  localparam int STRETCH_NUM  = 1392;
  localparam int STRETCH_DEN  = 1000;
  localparam int RAMP_DS [8]  = '{375, 188, 125, 75, 47, 31, 16, 8};
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF  = 8'h00;

  typedef struct packed {
    logic [7:0] target;   // Curve duty
    logic [7:0] min_duty; // Minimum duty
    logic [1:0] chan;     // Controlling channel
  } duty_req_t;

endpackage

// [logic/fan_limit_hysteresis_ramp.sv]
/*
  Fan duty post-processing: critical-limit override with hysteresis,
  on/off hysteresis around the minimum temperature, ramp limiting.
  Assumes temperatures, minimum temperatures and curve targets come from
  logic on mclk; registers are reached over Avalon-MM.
*/
`timescale 1ns/1ps

// Functional notes
// - Limit duty change rate per channel setting
// - Step gradually toward target, rising or falling, stop there
// - Any channel over limit forces full duty
// - Hold full until below limit minus hysteresis
// - Override beats curve, clamp and ramp
// - Three 8-bit critical limits, reset 0x64
// - Shared register: remote one high, local low
// - Remote two hysteresis in high nibble
// - One hysteresis for on/off and override
// - Hysteresis 4-bit degrees, zero disables it
// - Keep running until below min minus hysteresis
// - Keep bit picks minimum duty over off
// - Keep-spinning output ignores on/off hysteresis
// - Slow bits make channel ramp four times slower, up to the TICK_MAX step cap
// - Stretch bit lengthens each ramp 39.2 percent, up to the TICK_MAX step cap
// - Remote one ramp code table, bits 2:0
// - Remote two ramp code, bits 6:4
// - Local ramp code, bits 2:0
module fan_limit_hysteresis_ramp #(
  parameter int NUM_OUT  = 3,
  parameter int TICK_MAX = 4_000_000
) (
  input  wire logic                           mclk,         // 20 MHz clock
  input  wire logic                           sys_rst,      // Sync reset, active high
  input  wire logic [7:0]                     avs_address,  // Byte address
  input  wire logic                           avs_read,     // Read request
  input  wire logic                           avs_write,    // Write request
  input  wire logic [31:0]                    avs_writedata, // Write data
  input  wire logic [3:0]                     avs_byteenable, // Byte lanes
  output logic      [31:0]                    avs_readdata, // Read data
  output logic                                avs_waitrequest, // Stall
  input  wire logic [2:0][7:0]                temp,         // Temperatures, 0 1 loc 2
  input  wire logic [2:0][7:0]                temp_min,     // Minimum temperatures
  input  wire fan_post_pkg::duty_req_t [NUM_OUT-1:0] duty_req, // Curve requests
  output logic      [NUM_OUT-1:0][7:0]        duty_out,     // Final duty
  output logic                                critical_thermal_override // Override on
);

  // ==========================================================================
  // Register file.
  logic [7:0] slowdown_reg;
  logic [7:0] acou_one_reg;
  logic [7:0] acou_two_reg;
  logic [2:0][7:0] crit_reg;
  logic [7:0] hyst_pair_reg;
  logic [7:0] hyst_r2_reg;
  logic       ack_reg;
  logic [7:0] rd_next;
  logic       wr_go;

  // A one-cycle wait gives every access a fixed two-cycle shape.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_go = avs_write & ack_reg & avs_byteenable[0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slowdown_reg  <= fan_post_pkg::RST_RAMP_SLOWDOWN;
      acou_one_reg  <= fan_post_pkg::RST_ACOUSTICS;
      acou_two_reg  <= fan_post_pkg::RST_ACOUSTICS;
      crit_reg      <= {3{fan_post_pkg::RST_CRIT_LIMIT}};
      hyst_pair_reg <= fan_post_pkg::RST_HYST_PAIR;
      hyst_r2_reg   <= fan_post_pkg::RST_HYST_R2;
    end else if (wr_go) begin
      case (avs_address)
        fan_post_pkg::OFF_RAMP_SLOWDOWN:    slowdown_reg  <= avs_writedata[7:0];
        fan_post_pkg::OFF_ACOUSTICS_ONE:    acou_one_reg  <= avs_writedata[7:0];
        fan_post_pkg::OFF_ACOUSTICS_TWO:    acou_two_reg  <= avs_writedata[7:0];
        fan_post_pkg::OFF_R1_CRIT_LIMIT:    crit_reg[0]   <= avs_writedata[7:0];
        fan_post_pkg::OFF_LOCAL_CRIT_LIMIT: crit_reg[1]   <= avs_writedata[7:0];
        fan_post_pkg::OFF_R2_CRIT_LIMIT:    crit_reg[2]   <= avs_writedata[7:0];
        fan_post_pkg::OFF_R1_LOCAL_HYST:    hyst_pair_reg <= avs_writedata[7:0];
        fan_post_pkg::OFF_R2_HYST:          hyst_r2_reg   <= {avs_writedata[7:4], 4'h0};
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Hysteresis and override state.
  logic [2:0][3:0] hyst;
  logic [2:0]      crit_latch_reg;
  logic [2:0]      crit_next;
  logic [2:0]      run_reg;
  logic [2:0]      run_next;

  always_comb begin
    hyst[0] = hyst_pair_reg[fan_post_pkg::HYST_HI_LSB +: 4];
    hyst[1] = hyst_pair_reg[fan_post_pkg::HYST_LO_LSB +: 4];
    hyst[2] = hyst_r2_reg[fan_post_pkg::HYST_HI_LSB +: 4];
  end

  // Temperature strictly below limit minus hysteresis; a zero hysteresis
  // collapses both thresholds onto the limit itself.
  function automatic logic below_band(input logic [7:0] t, input logic [7:0] lim,
                                      input logic [3:0] h);
    logic [8:0] t_plus;
    t_plus = {1'b0, t} + {5'h00, h};
    return t_plus < {1'b0, lim};
  endfunction

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      if (temp[c] > crit_reg[c]) begin
        crit_next[c] = 1'b1;
      end else if (below_band(temp[c], crit_reg[c], hyst[c])) begin
        crit_next[c] = 1'b0;
      end else begin
        crit_next[c] = crit_latch_reg[c];
      end
      if (temp[c] > temp_min[c]) begin
        run_next[c] = 1'b1;
      end else if (below_band(temp[c], temp_min[c], hyst[c])) begin
        run_next[c] = 1'b0;
      end else begin
        run_next[c] = run_reg[c];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      crit_latch_reg <= 3'b000;
      run_reg        <= 3'b000;
    end else begin
      crit_latch_reg <= crit_next;
      run_reg        <= run_next;
    end
  end

  assign critical_thermal_override = |crit_latch_reg;

  // ==========================================================================
  // Ramp interval per channel.
  function automatic logic [2:0] ramp_code(input logic [1:0] ch,
                                           input logic [7:0] a1, input logic [7:0] a2);
    case (ch)
      2'd0:    return a1[fan_post_pkg::RAMP_LO_LSB +: 3];
      2'd1:    return a2[fan_post_pkg::RAMP_LO_LSB +: 3];
      default: return a2[fan_post_pkg::RAMP_HI_LSB +: 3];
    endcase
  endfunction

  // Cycles per duty step: ramp time / 255, times 4 when slowed, times
  // 1.392 when stretched, capped at TICK_MAX. Computed in 64 bits to avoid overflow.
  function automatic logic [31:0] step_cycles(input logic [2:0] code,
                                              input logic slow, input logic stretch);
    longint cyc;
    cyc = longint'(fan_post_pkg::RAMP_DS[code]) * fan_post_pkg::CLK_HZ
          / (10 * fan_post_pkg::DUTY_STEPS);
    if (slow) begin
      cyc = cyc * fan_post_pkg::SLOW_FACTOR;
    end
    if (stretch) begin
      cyc = cyc * fan_post_pkg::STRETCH_NUM / fan_post_pkg::STRETCH_DEN;
    end
    if (cyc > TICK_MAX) begin
      cyc = TICK_MAX;
    end
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[31:0];
  endfunction

  logic [2:0][31:0] tick_cnt_reg;
  logic [2:0]       tick;
  logic [2:0][31:0] limit_c;

  always_comb begin
    for (int c = 0; c < 3; c++) begin
      limit_c[c] = step_cycles(ramp_code(2'(c), acou_one_reg, acou_two_reg),
                               slowdown_reg[c], slowdown_reg[fan_post_pkg::STRETCH_BIT]);
      tick[c] = (tick_cnt_reg[c] + 32'h00000001 >= limit_c[c]);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tick_cnt_reg <= '0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        tick_cnt_reg[c] <= tick[c] ? 32'h00000000 : tick_cnt_reg[c] + 32'h00000001;
      end
    end
  end

  // ==========================================================================
  // Per-output duty selection and ramp.
  logic [NUM_OUT-1:0][7:0] goal;
  logic [NUM_OUT-1:0][7:0] duty_next;

  always_comb begin
    for (int o = 0; o < NUM_OUT; o++) begin
      logic [1:0] ch;
      logic       keep;
      ch = duty_req[o].chan;
      keep = (o < 3) ? acou_one_reg[fan_post_pkg::KEEP_ONE_BIT + o] : 1'b0;
      if (ch > 2'd2) begin
        ch = 2'd2;
      end
      if (temp[ch] > temp_min[ch]) begin
        goal[o] = duty_req[o].target;
      end else if (keep) begin
        goal[o] = duty_req[o].min_duty;
      end else if (run_reg[ch]) begin
        goal[o] = duty_req[o].min_duty;
      end else begin
        goal[o] = fan_post_pkg::DUTY_OFF;
      end
      if (critical_thermal_override) begin
        duty_next[o] = fan_post_pkg::DUTY_FULL;
      end else if (!tick[ch] || duty_out[o] == goal[o]) begin
        duty_next[o] = duty_out[o];
      end else if (duty_out[o] < goal[o]) begin
        duty_next[o] = duty_out[o] + 8'h01;
      end else begin
        duty_next[o] = duty_out[o] - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      duty_out <= '0;
    end else begin
      duty_out <= duty_next;
    end
  end

  // ==========================================================================
  // Read path.
  always_comb begin
    case (avs_address)
      fan_post_pkg::OFF_RAMP_SLOWDOWN:    rd_next = slowdown_reg;
      fan_post_pkg::OFF_ACOUSTICS_ONE:    rd_next = acou_one_reg;
      fan_post_pkg::OFF_ACOUSTICS_TWO:    rd_next = acou_two_reg;
      fan_post_pkg::OFF_R1_CRIT_LIMIT:    rd_next = crit_reg[0];
      fan_post_pkg::OFF_LOCAL_CRIT_LIMIT: rd_next = crit_reg[1];
      fan_post_pkg::OFF_R2_CRIT_LIMIT:    rd_next = crit_reg[2];
      fan_post_pkg::OFF_R1_LOCAL_HYST:    rd_next = hyst_pair_reg;
      fan_post_pkg::OFF_R2_HYST:          rd_next = hyst_r2_reg;
      fan_post_pkg::OFF_STATUS:           rd_next = {2'b00, run_reg, crit_latch_reg};
      default:                            rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= {24'h000000, rd_next};
    end
  end

endmodule

// [testbench/fan_post_monitor.sv]
/*
  Checker for the fan duty post-processing block.
  Bound to the design top by the testbench and sees only its ports.
*/
`timescale 1ns/1ps
module fan_post_monitor #(
  parameter int NUM_OUT = 3
) (
  input wire logic                    mclk,                     // Clock
  input wire logic                    sys_rst,                  // Sync reset
  input wire logic                    avs_read,                 // Read request
  input wire logic                    avs_write,                // Write request
  input wire logic [31:0]             avs_readdata,             // Read data
  input wire logic                    avs_waitrequest,          // Stall
  input wire logic [NUM_OUT-1:0][7:0] duty_out,                 // Final duty
  input wire logic                    critical_thermal_override // Override
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Register bus.
  a_bus_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus request not answered next cycle");
  a_idle_no_stall: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("stall while idle");
  a_data_upper_zero: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  // ==========================================================================
  // Duty path.
  a_reset_clears: assert property ($past(sys_rst) |-> duty_out == '0 &&
    !critical_thermal_override) else $error("outputs not cleared by reset");
  a_override_full: assert property (critical_thermal_override |=> &duty_out)
    else $error("override without full duty");
  a_ramp_step_first: assert property (!$past(critical_thermal_override) |->
    duty_out[0] == $past(duty_out[0]) || duty_out[0] == $past(duty_out[0]) + 8'h01
    || duty_out[0] + 8'h01 == $past(duty_out[0])) else $error("first duty jumped");
  a_ramp_step_last: assert property (!$past(critical_thermal_override) |->
    duty_out[NUM_OUT-1] == $past(duty_out[NUM_OUT-1])
    || duty_out[NUM_OUT-1] == $past(duty_out[NUM_OUT-1]) + 8'h01
    || duty_out[NUM_OUT-1] + 8'h01 == $past(duty_out[NUM_OUT-1]))
    else $error("last duty jumped");
endmodule

// [testbench/fan_bank_model.sv]
/*
  Behavioural bank of fans driven by the duty outputs.
  Assumes the duty arrives registered on mclk.
*/
`timescale 1ns/1ps
module fan_bank_model #(
  parameter int NUM_OUT = 3
) (
  input wire logic                    mclk,     // Clock
  input wire logic [NUM_OUT-1:0][7:0] duty_out, // Drive per fan
  output logic     [NUM_OUT-1:0]      at_full   // Fan at full speed
);
  // A rotor lags its drive, so full speed shows one cycle late.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_OUT; i++) begin
      at_full[i] <= (duty_out[i] == 8'hFF);
    end
  end
endmodule

// [testbench/tb_top.sv]
/*
  Self-checking bench for the fan duty post-processing block.
  Assumes the design package is compiled first; ramp ticks are capped short.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  localparam int NO = 3;
  typedef struct {logic [7:0] a, rst, wd, rb;} reg_row_t;
  logic                            mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic                            critical_thermal_override;
  logic [7:0]                      avs_address, rd;
  logic [31:0]                     avs_writedata, avs_readdata;
  logic [2:0][7:0]                 temp, temp_min;
  fan_post_pkg::duty_req_t [NO-1:0] duty_req;
  logic [NO-1:0][7:0]              duty_out;
  logic [NO-1:0]                   at_full;
  int                              err_total = 0, samples_checked = 0, cyc = 0;
  logic [7:0]                      lim [3] = '{8'h64, 8'h70, 8'h64};
  logic [7:0]                      hys [3] = '{8'h05, 8'h03, 8'h04};
  reg_row_t rows [9] = '{'{8'h10, 8'h00, 8'h00, 8'h00}, '{8'h62, 8'h00, 8'h07, 8'h07},
    '{8'h63, 8'h00, 8'h77, 8'h77}, '{8'h6A, 8'h64, 8'h64, 8'h64},
    '{8'h6B, 8'h64, 8'h70, 8'h70}, '{8'h6C, 8'h64, 8'h64, 8'h64},
    '{8'h6D, 8'h44, 8'h53, 8'h53}, '{8'h6E, 8'h40, 8'h4F, 8'h40},
    '{8'h20, 8'h00, 8'h5A, 8'h00}};

  fan_limit_hysteresis_ramp #(.NUM_OUT(NO), .TICK_MAX(4)) i_fan_limit_hysteresis_ramp (
    .mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .temp(temp),
    .temp_min(temp_min), .duty_req(duty_req), .duty_out(duty_out),
    .critical_thermal_override(critical_thermal_override));
  fan_bank_model #(.NUM_OUT(NO)) i_fan_bank_model (.mclk(mclk), .duty_out(duty_out),
    .at_full(at_full));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h000000, wd};
    do begin @(posedge mclk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) err_total++;
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic set_temp(input int ch, input logic [7:0] v);
    @(posedge mclk);
    temp[ch] <= v;
  endtask

  task automatic wait_duty(input int i, input logic [7:0] v);
    int n;
    n = 0;
    while (duty_out[i] !== v && n < 3000) begin @(posedge mclk); n++; end
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin err_total++; wrap_up(); end
  end

  initial begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    temp = {3{8'h32}};
    temp_min = {3{8'h28}};
    for (int i = 0; i < NO; i++) duty_req[i] = '{8'h08, 8'h08, 2'(i)};
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("ramp_gradual", 1'b1, duty_out[0] < 8'h08)
    foreach (rows[k]) begin
      bus(1'b0, rows[k].a, 8'h00);
      `CHK("reset_value", rows[k].rst, rd)
      bus(1'b1, rows[k].a, rows[k].wd);
      bus(1'b0, rows[k].a, 8'h00);
      `CHK("readback", rows[k].rb, rd)
    end
    // ========================================================================
    // On/off hysteresis and keep-spinning around the minimum temperature.
    wait_duty(0, 8'h08);
    `CHK("duty_on", 8'h08, duty_out[0])
    set_temp(0, 8'h23);
    repeat (40) @(posedge mclk);
    `CHK("duty_hold", 8'h08, duty_out[0])
    set_temp(0, 8'h22);
    wait_duty(0, 8'h00);
    `CHK("duty_off", 8'h00, duty_out[0])
    bus(1'b1, 8'h62, 8'h27);
    wait_duty(0, 8'h08);
    `CHK("duty_keep", 8'h08, duty_out[0])
    set_temp(0, 8'h32);
    // ========================================================================
    // Critical override per channel, held to the hysteresis boundary.
    for (int ch = 0; ch < 3; ch++) begin
      set_temp(ch, lim[ch] + 8'h01);
      repeat (3) @(posedge mclk);
      `CHK("override_on", 1'b1, critical_thermal_override)
      `CHK("full_duty", {NO{8'hFF}}, duty_out)
      @(posedge mclk);
      `CHK("fans_full", {NO{1'b1}}, at_full)
      set_temp(ch, lim[ch] - hys[ch]);
      repeat (20) @(posedge mclk);
      `CHK("override_hold", 1'b1, critical_thermal_override)
      set_temp(ch, lim[ch] - hys[ch] - 8'h01);
      repeat (3) @(posedge mclk);
      `CHK("override_off", 1'b0, critical_thermal_override)
      set_temp(ch, 8'h32);
    end
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    `CHK("reset_duty", {NO{8'h00}}, duty_out)
    bus(1'b0, 8'h6B, 8'h00);
    `CHK("limit_reset", 8'h64, rd)
    wrap_up();
  end
endmodule

bind fan_limit_hysteresis_ramp fan_post_monitor #(.NUM_OUT(NUM_OUT)) u_mon (
  .mclk(mclk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .duty_out(duty_out),
  .critical_thermal_override(critical_thermal_override));
